// ---- common/pfs_cfg.svh ----
/*
  Constants of the program flash self-access controller: register offsets,
  control bit positions, reset values, unlock codes and timing.
  Assumes a 50 MHz system clock and an 8-bit register port.
*/
// Overview of operation
// - A 14-bit program word sits split across the data high and low registers.
// - Address high and low registers together form a 15-bit word address.
// - An internal timer times every self-access row erase and row programming operation.
// - Readout lock at 0 refuses external reads and writes, not self-access.
// - An external bulk erase clears the whole memory, all latches and the readout lock.
// - The two-bit guard field refuses self-modify in its region only.
// - Upper address byte from address high, lower byte from address low.
// - Software may set fetch and commit triggers but never clear them.
// - Hardware clears fetch or commit trigger when its operation ends.
// - Erase or programming starts only while modify-allow is set.
// - Modify-allow is cleared at power-up.
// - Reset during programming sets the interrupted flag, which survives reset.
// - The unlock port is write-only and reads back as zero.
// - No self-access latch or array change happens without the unlock sequence first.
// - Flash is in rows of 32 words; a row is the smallest erase.
// - Thirty-two 14-bit row latches, loaded only through the data registers.
// - Unprogrammed words may be programmed without a prior row erase.
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// Register offsets on the 3-bit register port
`define PFS_OFF_ADDR_LOW   3'h0
`define PFS_OFF_ADDR_HIGH  3'h1
`define PFS_OFF_DATA_LOW   3'h2
`define PFS_OFF_DATA_HIGH  3'h3
`define PFS_OFF_CTRL       3'h4
`define PFS_OFF_UNLOCK     3'h5

// Control register bit positions
`define PFS_BIT_FETCH      0
`define PFS_BIT_COMMIT     1
`define PFS_BIT_ALLOW      2
`define PFS_BIT_INTR       3
`define PFS_BIT_ERASE      4
`define PFS_BIT_LATCH      5

// Unlock codes and progress of the unlock sequence
`define PFS_UNLOCK_CODE1   8'h55
`define PFS_UNLOCK_CODE2   8'haa
`define PFS_UNL_NONE       2'h0
`define PFS_UNL_ONE        2'h1
`define PFS_UNL_TWO        2'h2

// Guard field codes and protected region tops
`define PFS_GUARD_OFF      2'h3
`define PFS_GUARD_LOW      2'h2
`define PFS_GUARD_HALF     2'h1
`define PFS_GUARD_LOW_TOP  15'h01ff
`define PFS_GUARD_HALF_TOP 15'h0fff

// Reset values
`define PFS_LOCK_RST       1'b1
`define PFS_FLAG_RST       1'b0

// Timing: programming and erase time, clock period
`define PFS_PROG_TIME_NS   2000000
`define PFS_CLK_PERIOD_NS  20
`define PFS_PROG_CYCLES    ((`PFS_PROG_TIME_NS + `PFS_CLK_PERIOD_NS - 1) / `PFS_CLK_PERIOD_NS)

`endif

// ---- common/pfs_pkg.sv ----
/*
  Types of the program flash self-access controller.
  Assumes the constants header is compiled alongside.
*/
package pfs_pkg;

  // Software control bits held in the resetn domain
  typedef struct packed {
    logic latch_only;
    logic erase_sel;
    logic modify_allow;
    logic commit;
    logic fetch;
  } pfs_ctrl_type;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_LATCH = 3'b010,
    ST_TIMED = 3'b011,
    ST_BULK  = 3'b100
  } pfs_state_type;

endpackage

// ---- design/pfs_flash_array.sv ----
/*
  Program flash array model: one read port, single word programming,
  whole-row erase and whole-row programming from the row latches.
  Assumes one operation per cycle chosen by the controller; contents
  start undefined until erased.
*/
`timescale 1ns/1ps
module pfs_flash_array #(
  parameter int ADDR_W = 15,
  parameter int DATA_W = 14,
  parameter int ROW_AW = 5
) (
  input  wire logic                           sys_clk,   // System clock
  input  wire logic                           ce,        // Clock enable
  input  wire logic                           rd_en,     // Read strobe
  input  wire logic [ADDR_W-1:0]              rd_addr,   // Read word address
  output logic      [DATA_W-1:0]              rd_data,   // Read word, one cycle later
  input  wire logic                           wr_en,     // Program one word
  input  wire logic [ADDR_W-1:0]              wr_addr,   // Word address to program
  input  wire logic [DATA_W-1:0]              wr_data,   // Word value to program
  input  wire logic                           erase_en,  // Erase one row
  input  wire logic                           prog_en,   // Program one row from latches
  input  wire logic [ADDR_W-ROW_AW-1:0]       row_sel,   // Row to erase or program
  input  wire logic [DATA_W*(2**ROW_AW)-1:0]  row_data   // Latch contents, word 0 lowest
);
  localparam int ROW_N = 2**ROW_AW;

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Programming only clears bits, so unprogrammed words need no erase first
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (rd_en) begin
        rd_data <= mem[rd_addr];
      end
      if (wr_en) begin
        mem[wr_addr] <= mem[wr_addr] & wr_data;
      end
      for (int i = 0; i < ROW_N; i++) begin
        if (erase_en) begin
          mem[{row_sel, ROW_AW'(i)}] <= '1;
        end else if (prog_en) begin
          mem[{row_sel, ROW_AW'(i)}] <= mem[{row_sel, ROW_AW'(i)}] & row_data[i*DATA_W +: DATA_W];
        end
      end
    end
  end

endmodule

// ---- design/pfs_nvm_ctrl.sv ----
/*
  Program flash self-access controller: address, data, control and unlock
  registers, fetch, latch load, timed row erase and row programming,
  external programmer port with readout lock and bulk erase.
  Assumes the register master and programmer port run on sys_clk, por_n is
  asserted whenever power comes up, and resetn is asserted with it.
*/
`timescale 1ns/1ps
`include "pfs_cfg.svh"
module pfs_nvm_ctrl #(
  parameter int ADDR_W      = 15,
  parameter int DATA_W      = 14,
  parameter int ROW_WORDS   = 32,
  parameter int PROG_CYCLES = `PFS_PROG_CYCLES
) (
  input  wire logic              sys_clk,       // System clock, 50 MHz
  input  wire logic              resetn,        // Any device reset, async, low
  input  wire logic              por_n,         // Power-on reset, async, low
  input  wire logic              ce,            // Clock enable, freezes state when low
  input  wire logic [2:0]        reg_addr,      // Register offset
  input  wire logic [7:0]        reg_wdata,     // Register write data
  input  wire logic              reg_wr,        // Register write strobe
  input  wire logic              reg_rd,        // Register read strobe
  output logic      [7:0]        reg_rdata,     // Register read data, cycle after strobe
  input  wire logic [1:0]        self_program_guard_field, // Self-modify guard config
  input  wire logic              ext_read,      // Programmer word read
  input  wire logic              ext_write,     // Programmer word program
  input  wire logic              ext_bulk,      // Programmer bulk erase
  input  wire logic              ext_lock_set,  // Programmer sets readout lock
  input  wire logic [ADDR_W-1:0] ext_addr,      // Programmer word address
  input  wire logic [DATA_W-1:0] ext_wdata,     // Programmer word data
  output logic      [DATA_W-1:0] ext_rdata,     // Programmer read word
  output logic                   ext_rvalid,    // Programmer read word valid
  output logic                   ext_refused,   // Programmer request refused
  output logic                   busy,          // Timed operation or bulk erase running
  output logic                   readout_lock   // Readout lock, 0 is locked
);
  localparam int ROW_AW = $clog2(ROW_WORDS);
  localparam int ROW_N  = 2**(ADDR_W-ROW_AW);
  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

  // Assertion clock and reset for every check in this module
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  pfs_pkg::pfs_ctrl_type        ctrl_r, ctrl_nxt;
  pfs_pkg::pfs_state_type       state_r, state_nxt;
  logic [7:0]                   addr_low_r, addr_low_nxt;
  logic [ADDR_W-9:0]            addr_high_r, addr_high_nxt;
  logic [7:0]                   data_low_r, data_low_nxt;
  logic [DATA_W-9:0]            data_high_r, data_high_nxt;
  logic [1:0]                   unlock_r, unlock_nxt;
  logic [31:0]                  cnt_r, cnt_nxt;
  logic [ADDR_W-ROW_AW-1:0]     row_r, row_nxt;
  logic                         op_erase_r, op_erase_nxt;
  logic [7:0]                   rdata_r, rdata_nxt;
  logic                         rvalid_r, rvalid_nxt;
  logic                         refused_r, refused_nxt;
  logic                         busy_r, busy_nxt;
  logic                         flag_r, flag_nxt;
  logic                         mark_r, mark_nxt;
  logic                         lock_r, lock_nxt;
  logic                         rst_seen_r;
  logic [DATA_W-1:0]            latch_r [ROW_WORDS];
  logic [DATA_W*ROW_WORDS-1:0]  latch_bus;
  logic                         latch_we, latch_clr;
  logic [ADDR_W-1:0]            word_addr;
  logic [DATA_W-1:0]            word_data;
  logic                         guard_hit;
  logic                         wr_ctrl, wr_unlock;
  logic                         arr_rd_en, arr_wr_en, arr_erase, arr_prog;
  logic [ADDR_W-1:0]            arr_rd_addr;
  logic [ADDR_W-ROW_AW-1:0]     arr_row;
  logic [DATA_W-1:0]            arr_rd_data;

  // Word address and word data from the register pairs
  assign word_addr = {addr_high_r, addr_low_r};
  assign word_data = {data_high_r, data_low_r};
  assign wr_ctrl   = reg_wr && (reg_addr == `PFS_OFF_CTRL);
  assign wr_unlock = reg_wr && (reg_addr == `PFS_OFF_UNLOCK);

  // Guard region check, external port is never guarded
  always_comb begin
    guard_hit = 1'b0;
    if (self_program_guard_field == `PFS_GUARD_OFF) begin
      guard_hit = 1'b0;
    end else if (self_program_guard_field == `PFS_GUARD_LOW) begin
      guard_hit = (word_addr <= `PFS_GUARD_LOW_TOP);
    end else if (self_program_guard_field == `PFS_GUARD_HALF) begin
      guard_hit = (word_addr <= `PFS_GUARD_HALF_TOP);
    end else begin
      guard_hit = 1'b1;
    end
  end

  // Unlock tracking: two codes back to back, then the commit write
  always_comb begin
    unlock_nxt = `PFS_UNL_NONE;
    if (wr_unlock && (reg_wdata == `PFS_UNLOCK_CODE1)) begin
      unlock_nxt = `PFS_UNL_ONE;
    end else if (wr_unlock && (reg_wdata == `PFS_UNLOCK_CODE2) && (unlock_r == `PFS_UNL_ONE)) begin
      unlock_nxt = `PFS_UNL_TWO;
    end else if (!reg_wr && !reg_rd) begin
      unlock_nxt = unlock_r;
    end
  end

  // Register writes, sequencer and array requests
  always_comb begin
    ctrl_nxt      = ctrl_r;
    state_nxt     = state_r;
    addr_low_nxt  = addr_low_r;
    addr_high_nxt = addr_high_r;
    data_low_nxt  = data_low_r;
    data_high_nxt = data_high_r;
    cnt_nxt       = cnt_r;
    row_nxt       = row_r;
    op_erase_nxt  = op_erase_r;
    rvalid_nxt    = 1'b0;
    refused_nxt   = 1'b0;
    latch_we      = 1'b0;
    latch_clr     = 1'b0;
    arr_rd_en     = 1'b0;
    arr_rd_addr   = word_addr;
    arr_wr_en     = 1'b0;
    arr_erase     = 1'b0;
    arr_prog      = 1'b0;
    arr_row       = row_r;
    if (reg_wr) begin
      if (reg_addr == `PFS_OFF_ADDR_LOW) begin
        addr_low_nxt = reg_wdata;
      end else if (reg_addr == `PFS_OFF_ADDR_HIGH) begin
        addr_high_nxt = reg_wdata[ADDR_W-9:0];
      end else if (reg_addr == `PFS_OFF_DATA_LOW) begin
        data_low_nxt = reg_wdata;
      end else if (reg_addr == `PFS_OFF_DATA_HIGH) begin
        data_high_nxt = reg_wdata[DATA_W-9:0];
      end else if (reg_addr == `PFS_OFF_CTRL) begin
        ctrl_nxt.modify_allow = reg_wdata[`PFS_BIT_ALLOW];
        ctrl_nxt.erase_sel    = reg_wdata[`PFS_BIT_ERASE];
        ctrl_nxt.latch_only   = reg_wdata[`PFS_BIT_LATCH];
        ctrl_nxt.fetch        = ctrl_r.fetch | reg_wdata[`PFS_BIT_FETCH];
        if (reg_wdata[`PFS_BIT_COMMIT] && !ctrl_r.commit && ctrl_r.modify_allow
            && (unlock_r == `PFS_UNL_TWO) && (state_r == pfs_pkg::ST_IDLE)) begin
          ctrl_nxt.commit = 1'b1;
        end
      end
    end
    case (state_r)
      pfs_pkg::ST_IDLE: begin
        if (ctrl_r.commit && ctrl_r.latch_only) begin
          state_nxt = pfs_pkg::ST_LATCH;
        end else if (ctrl_r.commit && guard_hit) begin
          ctrl_nxt.commit = 1'b0;
        end else if (ctrl_r.commit) begin
          state_nxt    = pfs_pkg::ST_TIMED;
          cnt_nxt      = PROG_LAST;
          row_nxt      = word_addr[ADDR_W-1:ROW_AW];
          op_erase_nxt = ctrl_r.erase_sel;
        end else if (ctrl_r.fetch) begin
          arr_rd_en = 1'b1;
          state_nxt = pfs_pkg::ST_FETCH;
        end else if (ext_bulk) begin
          state_nxt = pfs_pkg::ST_BULK;
          row_nxt   = '0;
        end else if ((ext_read || ext_write) && !lock_r) begin
          refused_nxt = 1'b1;
        end else if (ext_read) begin
          arr_rd_en   = 1'b1;
          arr_rd_addr = ext_addr;
          rvalid_nxt  = 1'b1;
        end else if (ext_write) begin
          arr_wr_en = 1'b1;
        end
      end
      pfs_pkg::ST_FETCH: begin
        data_low_nxt  = arr_rd_data[7:0];
        data_high_nxt = arr_rd_data[DATA_W-1:8];
        ctrl_nxt.fetch = 1'b0;
        state_nxt     = pfs_pkg::ST_IDLE;
      end
      pfs_pkg::ST_LATCH: begin
        latch_we        = 1'b1;
        ctrl_nxt.commit = 1'b0;
        state_nxt       = pfs_pkg::ST_IDLE;
      end
      pfs_pkg::ST_TIMED: begin
        cnt_nxt = cnt_r - 32'h1;
        if (cnt_r == 32'h0) begin
          arr_erase       = op_erase_r;
          arr_prog        = !op_erase_r;
          latch_clr       = !op_erase_r;
          ctrl_nxt.commit = 1'b0;
          state_nxt       = pfs_pkg::ST_IDLE;
        end
      end
      pfs_pkg::ST_BULK: begin
        arr_erase = 1'b1;
        row_nxt   = row_r + 1'b1;
        if (row_r == (ADDR_W-ROW_AW)'(ROW_N - 1)) begin
          latch_clr = 1'b1;
          state_nxt = pfs_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = pfs_pkg::ST_IDLE;
      end
    endcase
    if ((ext_read || ext_write || ext_bulk) && (state_r != pfs_pkg::ST_IDLE || ctrl_r.commit || ctrl_r.fetch)) begin
      refused_nxt = 1'b1;
    end
    busy_nxt = (state_nxt == pfs_pkg::ST_TIMED) || (state_nxt == pfs_pkg::ST_BULK);
  end

  // Read data: one cycle after the strobe, zero elsewhere
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `PFS_OFF_ADDR_LOW) begin
        rdata_nxt = addr_low_r;
      end else if (reg_addr == `PFS_OFF_ADDR_HIGH) begin
        rdata_nxt = 8'(addr_high_r);
      end else if (reg_addr == `PFS_OFF_DATA_LOW) begin
        rdata_nxt = data_low_r;
      end else if (reg_addr == `PFS_OFF_DATA_HIGH) begin
        rdata_nxt = 8'(data_high_r);
      end else if (reg_addr == `PFS_OFF_CTRL) begin
        rdata_nxt = {2'b00, ctrl_r.latch_only, ctrl_r.erase_sel, flag_r,
                     ctrl_r.modify_allow, ctrl_r.commit, ctrl_r.fetch};
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  // Power-on domain: interrupted flag, in-progress mark, readout lock
  always_comb begin
    flag_nxt = flag_r;
    mark_nxt = mark_r;
    lock_nxt = lock_r;
    if (wr_ctrl && !reg_wdata[`PFS_BIT_INTR]) begin
      flag_nxt = 1'b0;
    end
    if (state_r == pfs_pkg::ST_TIMED) begin
      mark_nxt = (cnt_r != 32'h0);
    end else if (rst_seen_r) begin
      flag_nxt = flag_nxt | mark_r; // Set wins over a clear in the same cycle
      mark_nxt = 1'b0;
    end
    if (state_r == pfs_pkg::ST_BULK) begin
      lock_nxt = 1'b1;
      flag_nxt = 1'b0;
    end else if (ext_lock_set && lock_r) begin
      lock_nxt = 1'b0;
    end
  end

  // State cleared by any reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r      <= '0;
      state_r     <= pfs_pkg::ST_IDLE;
      addr_low_r  <= '0;
      addr_high_r <= '0;
      data_low_r  <= '0;
      data_high_r <= '0;
      unlock_r    <= `PFS_UNL_NONE;
      cnt_r       <= '0;
      row_r       <= '0;
      op_erase_r  <= 1'b0;
      rdata_r     <= '0;
      rvalid_r    <= 1'b0;
      refused_r   <= 1'b0;
      busy_r      <= 1'b0;
      rst_seen_r  <= 1'b1;
    end else if (ce) begin
      ctrl_r      <= ctrl_nxt;
      state_r     <= state_nxt;
      addr_low_r  <= addr_low_nxt;
      addr_high_r <= addr_high_nxt;
      data_low_r  <= data_low_nxt;
      data_high_r <= data_high_nxt;
      unlock_r    <= unlock_nxt;
      cnt_r       <= cnt_nxt;
      row_r       <= row_nxt;
      op_erase_r  <= op_erase_nxt;
      rdata_r     <= rdata_nxt;
      rvalid_r    <= rvalid_nxt;
      refused_r   <= refused_nxt;
      busy_r      <= busy_nxt;
      rst_seen_r  <= 1'b0;
    end
  end

  // State that survives resets other than power-on
  always_ff @(posedge sys_clk or negedge por_n) begin
    if (!por_n) begin
      flag_r <= `PFS_FLAG_RST;
      mark_r <= 1'b0;
      lock_r <= `PFS_LOCK_RST;
    end else if (ce) begin
      flag_r <= flag_nxt;
      mark_r <= mark_nxt;
      lock_r <= lock_nxt;
    end
  end

  // Row latches, erased value after reset and after each use
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < ROW_WORDS; i++) begin
        latch_r[i] <= '1;
      end
    end else if (ce) begin
      for (int i = 0; i < ROW_WORDS; i++) begin
        if (latch_clr) begin
          latch_r[i] <= '1;
        end else if (latch_we && (word_addr[ROW_AW-1:0] == ROW_AW'(i))) begin
          latch_r[i] <= word_data;
        end
      end
    end
  end

  // Flatten latches for the array, word 0 lowest
  always_comb begin
    for (int i = 0; i < ROW_WORDS; i++) begin
      latch_bus[i*DATA_W +: DATA_W] = latch_r[i];
    end
  end

  pfs_flash_array #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .ROW_AW(ROW_AW)) u_array (
    .sys_clk  (sys_clk),
    .ce       (ce),
    .rd_en    (arr_rd_en),
    .rd_addr  (arr_rd_addr),
    .rd_data  (arr_rd_data),
    .wr_en    (arr_wr_en),
    .wr_addr  (ext_addr),
    .wr_data  (ext_wdata),
    .erase_en (arr_erase),
    .prog_en  (arr_prog),
    .row_sel  (arr_row),
    .row_data (latch_bus)
  );

  assign reg_rdata    = rdata_r;
  assign ext_rdata    = arr_rd_data;
  assign ext_rvalid   = rvalid_r;
  assign ext_refused  = refused_r;
  assign busy         = busy_r;
  assign readout_lock = lock_r;

  // Checks on the sequencer and register behaviour

  sequence s_commit_set;
    ce && !ctrl_r.commit ##1 ctrl_r.commit;
  endsequence
  sequence s_timed_start;
    ce && state_r == pfs_pkg::ST_IDLE ##1 state_r == pfs_pkg::ST_TIMED;
  endsequence

  a_unlock_reads_zero:
    assert property (ce && reg_rd && reg_addr == `PFS_OFF_UNLOCK |=> reg_rdata == 8'h00)
      else $error("unlock port read returned nonzero");
  a_fetch_completes:
    assert property ($rose(ctrl_r.fetch) && state_r == pfs_pkg::ST_IDLE && ce ##1 ce |=> !ctrl_r.fetch)
      else $error("fetch trigger not cleared after read");
  a_commit_unlocked:
    assert property (s_commit_set |-> $past(unlock_r) == `PFS_UNL_TWO)
      else $error("commit accepted without unlock");
  a_commit_allowed:
    assert property (s_commit_set |-> $past(ctrl_r.modify_allow))
      else $error("commit accepted without modify allow");
  a_commit_no_clear:
    assert property (ce && ctrl_r.commit && state_r == pfs_pkg::ST_TIMED && cnt_r > 32'h1
                     && wr_ctrl && !reg_wdata[`PFS_BIT_COMMIT] |=> ctrl_r.commit)
      else $error("software cleared commit trigger");
  a_timer_loaded:
    assert property (s_timed_start |-> cnt_r == PROG_LAST && busy)
      else $error("programming timer not loaded");
  a_guard_blocks:
    assert property (ce && state_r == pfs_pkg::ST_IDLE && ctrl_r.commit && !ctrl_r.latch_only && guard_hit
                     |=> state_r == pfs_pkg::ST_IDLE && !ctrl_r.commit)
      else $error("guarded row was modified");
  a_lock_refuses:
    assert property (ce && state_r == pfs_pkg::ST_IDLE && !ctrl_r.commit && !ctrl_r.fetch && !ext_bulk
                     && ext_read && !readout_lock |=> ext_refused && !ext_rvalid)
      else $error("locked external read not refused");
  a_latch_loads:
    assert property (ce && state_r == pfs_pkg::ST_LATCH |=> latch_r[$past(word_addr[ROW_AW-1:0])] == $past(word_data)
                     && !ctrl_r.commit)
      else $error("row latch not loaded");

endmodule

// ---- test/program_flash_self_access_test.sv ----
/*
  Self-checking bench of the program flash self-access controller.
  Assumes the constants header and the design files are compiled first.
*/
`timescale 1ns/1ps
module program_flash_self_access_test;
  logic        sys_clk = 1'b0, resetn = 1'b0, por_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        ext_read = 1'b0, ext_write = 1'b0, ext_bulk = 1'b0, ext_lock_set = 1'b0, ce = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, v;
  logic [1:0]  guard = 2'h3;
  logic [14:0] ext_addr = 15'h0000;
  logic [13:0] ext_wdata = 14'h0000, ext_rdata;
  logic        ext_rvalid, ext_refused, busy, readout_lock;
  int          fail_count = 0, comparisons = 0, cycles = 0;
  logic [2:0]  ta [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h4};
  logic [7:0]  tw [7] = '{8'h12, 8'hff, 8'hab, 8'hff, 8'h55, 8'hff, 8'h00};
  logic [7:0]  te [7] = '{8'h12, 8'h7f, 8'hab, 8'h3f, 8'h00, 8'h00, 8'h00};

  pfs_nvm_ctrl #(.PROG_CYCLES(8)) i_pfs_nvm_ctrl (
    .sys_clk(sys_clk), .resetn(resetn), .por_n(por_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .self_program_guard_field(guard), .ext_read(ext_read), .ext_write(ext_write),
    .ext_bulk(ext_bulk), .ext_lock_set(ext_lock_set), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata), .ext_rvalid(ext_rvalid), .ext_refused(ext_refused), .busy(busy),
    .readout_lock(readout_lock));

  // Clock and hang guard
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One-cycle register write and read; read data sampled in the cycle after the strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic unlock();
    wr(3'h5, 8'h55);
    wr(3'h5, 8'haa);
  endtask
  // Programmer pulse: 0 read, 1 write, 2 bulk, 3 lock; answer sampled one cycle on
  task automatic ext(input int k);
    @(posedge sys_clk);
    ext_read     <= (k == 0);
    ext_write    <= (k == 1);
    ext_bulk     <= (k == 2);
    ext_lock_set <= (k == 3);
    @(posedge sys_clk);
    {ext_read, ext_write, ext_bulk, ext_lock_set} <= 4'h0;
    #1;
  endtask
  task automatic wait_idle(input int n);
    repeat (n) if (busy === 1'b1) @(posedge sys_clk);
    #1 chk("busy", {15'h0, busy}, 16'h0000);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    por_n  <= 1'b1;
    rd(3'h4);
    chk("ctrl after power", {8'h0, v}, 16'h0000);
    // Register table: write each row, read back
    for (int i = 0; i < 7; i++) begin
      wr(ta[i], tw[i]);
      rd(ta[i]);
      chk("reg row", {8'h0, v}, {8'h0, te[i]});
    end
    // Clock enable low freezes the registers
    ce <= 1'b0;
    wr(3'h0, 8'h77);
    ce <= 1'b1;
    rd(3'h0);
    chk("ce freeze", {8'h0, v}, 16'h0012);
    // Lock refuses programmer read, bulk erase lifts it
    ext(3);
    chk("lock", {15'h0, readout_lock}, 16'h0000);
    ext(0);
    chk("locked read", {15'h0, ext_refused}, 16'h0001);
    ext(2);
    wait_idle(1100);
    chk("lock lifted", {15'h0, readout_lock}, 16'h0001);
    // Guard does not restrict the programmer
    guard     <= 2'h0;
    ext_addr  <= 15'h0040;
    ext_wdata <= 14'h1555;
    ext(1);
    chk("ext write", {15'h0, ext_refused}, 16'h0000);
    ext(0);
    chk("ext read", {ext_rvalid, 1'b0, ext_rdata}, 16'h9555);
    guard <= 2'h3;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    // Commit without modify-allow, then without unlock
    unlock();
    wr(3'h4, 8'h02);
    rd(3'h4);
    chk("no allow", {8'h0, v}, 16'h0000);
    wr(3'h4, 8'h04);
    wr(3'h4, 8'h06);
    cyc(2);
    chk("no unlock", {15'h0, busy}, 16'h0000);
    // Latch load, timed program with a refused clear, fetch back
    wr(3'h2, 8'ha5);
    wr(3'h3, 8'h00);
    unlock();
    wr(3'h4, 8'h26);
    cyc(3);
    rd(3'h4);
    chk("latch done", {8'h0, v}, 16'h0024);
    unlock();
    wr(3'h4, 8'h06);
    cyc(2);
    chk("timed busy", {15'h0, busy}, 16'h0001);
    wr(3'h4, 8'h04);
    rd(3'h4);
    chk("commit held", {8'h0, v}, 16'h0006);
    wait_idle(30);
    rd(3'h4);
    chk("commit clear", {8'h0, v}, 16'h0004);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h05);
    cyc(4);
    rd(3'h4);
    chk("fetch clear", {8'h0, v}, 16'h0004);
    rd(3'h2);
    chk("word low", {8'h0, v}, 16'h00a5);
    rd(3'h3);
    chk("word high", {8'h0, v}, 16'h0000);
    // Row read back above; erase it, then fetch the erased word
    unlock();
    wr(3'h4, 8'h16);
    cyc(2);
    wait_idle(30);
    wr(3'h4, 8'h15);
    cyc(4);
    rd(3'h2);
    chk("erased low", {8'h0, v}, 16'h00ff);
    rd(3'h3);
    chk("erased high", {8'h0, v}, 16'h003f);
    // Guarded region refuses self-programming
    guard <= 2'h2;
    unlock();
    wr(3'h4, 8'h06);
    cyc(3);
    chk("guarded", {15'h0, busy}, 16'h0000);
    rd(3'h4);
    chk("guard ctrl", {8'h0, v}, 16'h0004);
    // Reset in mid-program leaves the interrupted flag
    guard <= 2'h3;
    unlock();
    wr(3'h4, 8'h06);
    cyc(3);
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    cyc(2);
    rd(3'h4);
    chk("interrupted", {8'h0, v}, 16'h0008);
    wr(3'h4, 8'h00);
    rd(3'h4);
    chk("flag cleared", {8'h0, v}, 16'h0000);
    finish_test();
  end
endmodule
